// file: verilog/temp_adc_pkg.sv
/*
 * constants for the temperature / voltage sensing converter serial control block.
 * assumes a 25 MHz system clock and a host serial master in clock mode 0.
 */
package temp_adc_pkg;
	// ************************************************************
	// clock and timing
	// ************************************************************
	localparam int CLOCK_HZ = 25000000;
	// internal master clock of the converter, modelled as a divider of the system clock
	localparam int MASTER_CLOCK_HZ = 62500;
	localparam int MASTER_DIV = CLOCK_HZ / MASTER_CLOCK_HZ;
	localparam logic [9:0] MASTER_DIV_LAST = 10'(MASTER_DIV - 1);
	// a voltage conversion takes 64 master periods, a temperature one 2 x 64 - 3
	localparam logic [7:0] VOLT_PERIODS = 8'h40;
	localparam logic [7:0] TEMP_PERIODS = 8'h7D;
	localparam logic [7:0] LOAD_PERIODS = 8'h03;
	// wake-up from shutdown and the standby modes, in microseconds (0.1 ms)
	localparam int WAKE_US = 100;
	localparam int WAKE_CYCLES = (WAKE_US * (CLOCK_HZ / 1000000));
	localparam logic [11:0] WAKE_LAST = 12'(WAKE_CYCLES - 1);

	// ************************************************************
	// command byte layout
	// ************************************************************
	localparam int START_BIT = 7;
	localparam logic [3:0] SETUP_FIXED = 4'h0;
	localparam logic [2:0] MEASURE_FIXED = 3'h2;
	localparam int REF_BIT = 0;
	localparam int PM_LO = 1;
	localparam int PM_HI = 2;
	localparam logic [3:0] SEL_TEMP_INT = 4'h7;
	localparam logic [3:0] SEL_TEMP_EXT1 = 4'hC;
	localparam logic [3:0] SEL_TEMP_EXT2 = 4'hD;
	localparam logic [3:0] SEL_SUPPLY = 4'hB;

	// ************************************************************
	// result layout
	// ************************************************************
	localparam logic [4:0] RESULT_BITS = 5'h10;
	localparam logic [2:0] BYTE_BITS = 3'h7;

	typedef enum logic [1:0] {
		PM_SHUTDOWN = 2'h0,
		PM_STANDBY_PLUS = 2'h1,
		PM_STANDBY = 2'h2,
		PM_NORMAL = 2'h3
	} power_mode_t;
endpackage : temp_adc_pkg

// file: verilog/pin_sync.sv
/*
 * three-stage synchroniser with agreement filter for one pin.
 * assumes the pin is asynchronous to clock_i; reset value given by parameter.
 */
`timescale 1ns/10ps
module pin_sync #(
	parameter logic INIT = 1'b0
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic pin_i,
	output logic level_o
);
	logic meta;
	logic stage2;
	logic stage3;

	// first stage feeds only the second one
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			meta <= INIT;
			stage2 <= INIT;
			stage3 <= INIT;
		end else begin
			meta <= pin_i;
			stage2 <= meta;
			stage3 <= stage2;
		end
	end

	// a change counts only once the second and third stages agree
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			level_o <= INIT;
		end else if (stage2 == stage3) begin
			level_o <= stage3;
		end
	end
endmodule : pin_sync

// file: verilog/temp_adc_serial_control.sv
/*
 * serial command decode, conversion sequencing and result shift-out of a
 * temperature and voltage sensing converter.
 * assumes a host serial master (mode 0) on select_n, serial clock and data in;
 * the analog result arrives on sample_data_i when a conversion ends.
 */
`timescale 1ns/10ps
// What this block does
// - sample data in on rising clock, select low
// - start bit is first one after framing
// - data out changes on falling edges, MSB first
// - temperature: 2 leading bits, 12 data, 2 zeros
// - voltage: 12 data, sub-bit, two zeros
// - power-up enters shutdown mode
// - setup byte then measure byte starts conversion
// - strobe low at last measure bit, high at end
// - conversions about 2.0ms temperature, 1.0ms voltage
// - MSB at strobe rise, then zeros after sixteen
// - select high freezes link, conversion continues
// - setup byte: start, 0000, mode, reference
// - measure byte: start, 010, input select
// - reference bit one selects internal reference
// - temperature always uses internal reference
// - mode field: shutdown, standby-plus, standby, normal
// - standby: all off, 0.1ms wake external reference; the block still drives internal_ref_on_o from the reference bit
// - standby-plus keeps reference buffer if internal reference, 0.1ms wake
// - shutdown clears result register when idle and no result pending
// - supply monitor converts quarter supply
// - temperature result in kelvin eighths
// - data out high impedance while select high
// - voltage conversion takes 64 master periods
// - temperature conversion takes 125 master periods
module temp_adc_serial_control
	import temp_adc_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic select_n_i,
	input wire logic serial_clock_i,
	input wire logic serial_data_i,
	input wire logic [13:0] sample_data_i,
	output logic serial_data_o,
	output logic serial_data_oe_o,
	output logic conversion_strobe,
	output logic power_mode_hi,
	output logic power_mode_lo,
	output logic internal_ref_on_o,
	output logic ref_buffer_on_o,
	output logic [3:0] input_sel_o,
	output logic converting_o
);
	typedef enum {
		CONV_IDLE,
		CONV_WAKE,
		CONV_RUN,
		CONV_DONE
	} conv_state_t;

	// ************************************************************
	// pin synchronisation
	// ************************************************************
	logic select_n;
	logic sclk;
	logic sdin;
	logic sclk_prev;
	logic sclk_rise;
	logic sclk_fall;

	pin_sync #(.INIT(1'b1)) sync_select (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.pin_i(select_n_i),
		.level_o(select_n)
	);
	pin_sync #(.INIT(1'b0)) sync_clock (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.pin_i(serial_clock_i),
		.level_o(sclk)
	);
	pin_sync #(.INIT(1'b0)) sync_data (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.pin_i(serial_data_i),
		.level_o(sdin)
	);

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			sclk_prev <= 1'b0;
		end else begin
			sclk_prev <= sclk;
		end
	end

	// the host clock is mode 0 and well below our rate, so edges are seen reliably
	assign sclk_rise = sclk & ~sclk_prev & ~select_n;
	assign sclk_fall = ~sclk & sclk_prev & ~select_n;

	// ************************************************************
	// input byte assembly
	// ************************************************************
	logic [7:0] in_shift;
	logic [2:0] in_count;
	logic in_busy;
	logic byte_done;
	logic [7:0] next_byte;
	logic is_setup;
	logic is_measure;
	logic hunt_ok;
	logic [4:0] out_count;
	logic result_pending;
	conv_state_t conv_state;

	assign next_byte = {in_shift[6:0], sdin};
	assign byte_done = sclk_rise & in_busy & (in_count == BYTE_BITS);
	assign is_setup = next_byte[6:3] == SETUP_FIXED;
	assign is_measure = next_byte[6:4] == MEASURE_FIXED;
	// start-bit hunting is open when idle and no result is pending or it is fully shifted out
	assign hunt_ok = (conv_state == CONV_IDLE) &&
		((out_count == RESULT_BITS) || !result_pending);

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			in_shift <= 8'h00;
			in_count <= 3'h0;
			in_busy <= 1'b0;
		end else if (select_n) begin
			// a fresh frame restarts the hunt for the start bit
			in_busy <= 1'b0;
			in_count <= 3'h0;
		end else if (sclk_rise) begin
			if (!in_busy) begin
				if (sdin && hunt_ok) begin
					in_busy <= 1'b1;
					in_shift <= 8'h01;
					in_count <= 3'h1;
				end
			end else begin
				in_shift <= next_byte;
				in_count <= in_count + 3'h1;
				if (in_count == BYTE_BITS) begin
					in_busy <= 1'b0;
				end
			end
		end
	end

	// ************************************************************
	// configuration
	// ************************************************************
	logic ref_internal;
	logic [1:0] power_mode;
	logic measure_hit;
	logic [3:0] next_sel;
	logic last_fall_pending;

	assign measure_hit = byte_done & is_measure;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			power_mode <= PM_SHUTDOWN;
			ref_internal <= 1'b0;
		end else if (byte_done && is_setup) begin
			power_mode <= next_byte[PM_HI:PM_LO];
			ref_internal <= next_byte[REF_BIT];
		end
	end

	// unmatched fixed bits fall through both decodes and change nothing
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			next_sel <= 4'h0;
			last_fall_pending <= 1'b0;
		end else if (measure_hit) begin
			next_sel <= next_byte[3:0];
			last_fall_pending <= 1'b1;
		end else if (sclk_fall || select_n) begin
			last_fall_pending <= 1'b0;
		end
	end

	// ************************************************************
	// conversion sequencing
	// ************************************************************
	logic [9:0] div_count;
	logic master_tick;
	logic [7:0] period_count;
	logic [7:0] period_last;
	logic [11:0] wake_count;
	logic [3:0] input_sel;
	logic temp_mode;
	logic start_conv;
	logic asleep;

	// strobe drops on the falling edge that ends the measure byte
	assign start_conv = last_fall_pending & sclk_fall & (conv_state == CONV_IDLE);
	assign temp_mode = (input_sel == SEL_TEMP_INT) || (input_sel == SEL_TEMP_EXT1) ||
		(input_sel == SEL_TEMP_EXT2);
	// 64 and 125 periods give about 1.0 and 2.0 ms here
	assign period_last = temp_mode ? TEMP_PERIODS : VOLT_PERIODS;
	assign master_tick = div_count == MASTER_DIV_LAST;
	// any low-power mode costs a wake-up before the converter runs
	assign asleep = power_mode != PM_NORMAL;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			div_count <= 10'h000;
		end else if (conv_state != CONV_RUN || master_tick) begin
			div_count <= 10'h000;
		end else begin
			div_count <= div_count + 10'h001;
		end
	end

	// conversion continues whatever select does
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			conv_state <= CONV_IDLE;
			period_count <= 8'h00;
			wake_count <= 12'h000;
			input_sel <= 4'h0;
		end else begin
			case (conv_state)
				CONV_IDLE: begin
					if (start_conv) begin
						input_sel <= next_sel;
						wake_count <= 12'h000;
						period_count <= 8'h00;
						conv_state <= asleep ? CONV_WAKE : CONV_RUN;
					end
				end
				CONV_WAKE: begin
					wake_count <= wake_count + 12'h001;
					if (wake_count == WAKE_LAST) begin
						conv_state <= CONV_RUN;
					end
				end
				CONV_RUN: begin
					if (master_tick) begin
						period_count <= period_count + 8'h01;
						if (period_count == period_last - 8'h01) begin
							conv_state <= CONV_DONE;
						end
					end
				end
				CONV_DONE: begin
					conv_state <= CONV_IDLE;
				end
				default: begin
					conv_state <= CONV_IDLE;
				end
			endcase
		end
	end

	// ************************************************************
	// result register and shift-out
	// ************************************************************
	logic [15:0] result;

	// temperature: 12-bit kelvin eighths value sits after two leading bits
	// voltage: 12-bit two's complement plus sub-bit; supply code is 256 x vdd / vref
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			result <= 16'h0000;
			out_count <= 5'h00;
			result_pending <= 1'b0;
		end else if (power_mode == PM_SHUTDOWN && conv_state == CONV_IDLE && !result_pending) begin
			result <= 16'h0000;
			out_count <= 5'h00;
		end else if (conv_state == CONV_DONE) begin
			result <= {sample_data_i, 2'b00};
			out_count <= 5'h00;
			result_pending <= 1'b1;
		end else if (sclk_fall && result_pending && out_count != RESULT_BITS) begin
			result <= {result[14:0], 1'b0};
			out_count <= out_count + 5'h01;
		end else if (start_conv) begin
			result_pending <= 1'b0;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			serial_data_o <= 1'b0;
			serial_data_oe_o <= 1'b0;
			conversion_strobe <= 1'b1;
			power_mode_hi <= 1'b0;
			power_mode_lo <= 1'b0;
			internal_ref_on_o <= 1'b0;
			ref_buffer_on_o <= 1'b0;
			input_sel_o <= 4'h0;
			converting_o <= 1'b0;
		end else begin
			serial_data_o <= result[15];
			serial_data_oe_o <= ~select_n;
			conversion_strobe <= ~(start_conv || (conv_state != CONV_IDLE &&
				conv_state != CONV_DONE));
			power_mode_hi <= power_mode[1];
			power_mode_lo <= power_mode[0];
			// temperature always on the internal reference
			internal_ref_on_o <= ref_internal || (conv_state != CONV_IDLE && temp_mode);
			ref_buffer_on_o <= (power_mode == PM_NORMAL) ||
				(power_mode == PM_STANDBY_PLUS && ref_internal);
			input_sel_o <= input_sel;
			converting_o <= conv_state == CONV_RUN;
		end
	end
endmodule : temp_adc_serial_control

// file: dv/host_master.sv
/* host serial master model, clock mode 0, idle clock low.
   assumes clock_i is the device system clock; 8 clocks a bit (320 ns). */
`timescale 1ns/10ps
module host_master (
	input wire logic clock_i,
	input wire logic dout_i,
	output logic select_n_o,
	output logic sclk_o,
	output logic sdata_o
);
	initial begin
		select_n_o = 1'b1;
		sclk_o = 1'b0;
		sdata_o = 1'b0;
	end

	// data moves with the fall; read late since the device answers a few clocks after it
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sdata_o <= tx[i];
			repeat (4) @(posedge clock_i);
			sclk_o <= 1'b1;
			// the answer needs seven clocks from the previous fall to reach the line
			repeat (4) @(posedge clock_i);
			rx[i] = dout_i;
			sclk_o <= 1'b0;
		end
	endtask : xfer

	task automatic sel(input logic low);
		repeat (8) @(posedge clock_i);
		select_n_o <= !low;
		if (!low) sdata_o <= ~sdata_o;
		repeat (8) @(posedge clock_i);
	endtask : sel
endmodule : host_master

// file: dv/temp_adc_serial_control_asserts.sv
/* port-level checks of the serial control block.
   assumes the package constants; bound to the block at the foot. */
`timescale 1ns/10ps
module temp_adc_serial_control_asserts
	import temp_adc_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic select_n_i,
	input wire logic serial_data_oe_o,
	input wire logic conversion_strobe,
	input wire logic power_mode_hi,
	input wire logic power_mode_lo,
	input wire logic internal_ref_on_o,
	input wire logic ref_buffer_on_o,
	input wire logic [3:0] input_sel_o,
	input wire logic converting_o
);
	localparam int V_LEN = 64 * MASTER_DIV;
	localparam int T_LEN = 125 * MASTER_DIV;
	localparam int SLACK = MASTER_DIV + WAKE_CYCLES;
	int sel_cnt;
	int low_cnt;
	logic is_temp;
	assign is_temp = input_sel_o inside {4'h7, 4'hC, 4'hD};

	// deselect age; 12 clocks clears the pin synchroniser latency
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) sel_cnt <= 0;
		else if (!select_n_i) sel_cnt <= 0;
		else if (sel_cnt < 100) sel_cnt <= sel_cnt + 1;
	end
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) low_cnt <= 0;
		else if (conversion_strobe) low_cnt <= 0;
		else low_cnt <= low_cnt + 1;
	end

	// ****
	// assertions
	// ****
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	a_idle_hiz: assert property (sel_cnt >= 12 |-> !serial_data_oe_o)
		else $error("output enabled while deselected");
	a_powerup_off: assert property ($fell(rst_i) |-> !power_mode_hi && !power_mode_lo)
		else $error("power mode not shutdown after reset");
	a_busy_strobe: assert property (converting_o |-> !conversion_strobe)
		else $error("strobe high while converting");
	a_conv_length: assert property ($rose(conversion_strobe) |->
		low_cnt >= (is_temp ? T_LEN : V_LEN) - MASTER_DIV &&
		low_cnt <= (is_temp ? T_LEN : V_LEN) + SLACK)
		else $error("conversion length out of range");
	a_desel_nostart: assert property (sel_cnt >= 12 |-> !$fell(conversion_strobe))
		else $error("conversion started while deselected");
	a_desel_mode: assert property (sel_cnt >= 12 |-> $stable({power_mode_hi, power_mode_lo}))
		else $error("mode changed while deselected");
	a_temp_intref: assert property (converting_o && is_temp |-> internal_ref_on_o)
		else $error("temperature conversion without internal reference");
	a_standby_buf: assert property (conversion_strobe && !power_mode_lo &&
		$stable({power_mode_hi, power_mode_lo}) |-> !ref_buffer_on_o)
		else $error("reference buffer on in standby or shutdown");

	c_conv_start: cover property ($fell(conversion_strobe));
	c_conv_end: cover property ($rose(conversion_strobe));
	c_temp_run: cover property (converting_o && is_temp);
endmodule : temp_adc_serial_control_asserts

bind temp_adc_serial_control temp_adc_serial_control_asserts chk_u (
	.clock_i(clock_i),
	.rst_i(rst_i),
	.select_n_i(select_n_i),
	.serial_data_oe_o(serial_data_oe_o),
	.conversion_strobe(conversion_strobe),
	.power_mode_hi(power_mode_hi),
	.power_mode_lo(power_mode_lo),
	.internal_ref_on_o(internal_ref_on_o),
	.ref_buffer_on_o(ref_buffer_on_o),
	.input_sel_o(input_sel_o),
	.converting_o(converting_o)
);

// file: dv/tb.sv
/* self-checking bench of the serial control block.
   assumes host_master as the far side and a 25 MHz system clock. */
`timescale 1ns/10ps
module tb;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic [13:0] sample_data_i = 14'h0;
	logic select_n_i, serial_clock_i, serial_data_i, serial_data_o, serial_data_oe_o;
	logic conversion_strobe, power_mode_hi, power_mode_lo, converting_o;
	logic internal_ref_on_o, ref_buffer_on_o, dout_line = 1'b0;
	logic [3:0] input_sel_o;
	int bad_count = 0;
	int n_tests = 0;
	int cycles = 0;

	always #20 clock_i = ~clock_i;
	// a released line must not keep its last value
	always @(posedge clock_i) dout_line <= serial_data_oe_o ? serial_data_o : ~dout_line;

	temp_adc_serial_control dut_u (.clock_i(clock_i), .rst_i(rst_i),
		.select_n_i(select_n_i), .serial_clock_i(serial_clock_i),
		.serial_data_i(serial_data_i), .sample_data_i(sample_data_i),
		.serial_data_o(serial_data_o), .serial_data_oe_o(serial_data_oe_o),
		.conversion_strobe(conversion_strobe), .power_mode_hi(power_mode_hi),
		.power_mode_lo(power_mode_lo), .internal_ref_on_o(internal_ref_on_o),
		.ref_buffer_on_o(ref_buffer_on_o), .input_sel_o(input_sel_o),
		.converting_o(converting_o));
	host_master host_u (.clock_i(clock_i), .dout_i(dout_line), .select_n_o(select_n_i),
		.sclk_o(serial_clock_i), .sdata_o(serial_data_i));

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : conclude

	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 95000) begin
			bad_count++;
			conclude();
		end
	end

	task automatic t_modes();
		logic [7:0] rx;
		logic [1:0] pm;
		logic rf;
		for (int i = 0; i < 4; i++) begin
			pm = 2'(i);
			rf = (i != 3);
			host_u.sel(1'b1);
			host_u.xfer(8'h00, rx);
			host_u.xfer({1'b1, 4'h0, pm, rf}, rx);
			host_u.sel(1'b0);
			check("mode", {14'h0, pm}, {14'h0, power_mode_hi, power_mode_lo});
			check("buffer", 16'(pm == 2'h3 || (pm == 2'h1 && rf)), 16'(ref_buffer_on_o));
		end
		check("int ref", 16'h0, 16'(internal_ref_on_o));
		$display("modes test done");
	endtask : t_modes

	task automatic t_ignore();
		logic [7:0] rx;
		host_u.xfer(8'h81, rx);
		host_u.sel(1'b1);
		host_u.xfer(8'h88, rx);
		host_u.xfer(8'hE5, rx);
		host_u.sel(1'b0);
		check("mode kept", 16'h3, {14'h0, power_mode_hi, power_mode_lo});
		check("no start", 16'h1, 16'(conversion_strobe));
		check("hi-z", 16'h0, 16'(serial_data_oe_o));
		$display("ignore test done");
	endtask : t_ignore

	task automatic t_conv(input logic [7:0] setup, input logic [7:0] cmd,
		input logic [13:0] smp, input int per);
		logic [7:0] rx;
		logic [15:0] word;
		int t0;
		word = {smp, 2'h0};
		sample_data_i <= smp;
		host_u.sel(1'b1);
		if (setup != 8'h00) host_u.xfer(setup, rx);
		host_u.xfer(cmd, rx);
		t0 = cycles;
		repeat (8) @(posedge clock_i);
		check("strobe", 16'h0, 16'(conversion_strobe));
		check("input sel", {12'h0, cmd[3:0]}, {12'h0, input_sel_o});
		host_u.sel(1'b0);
		while (conversion_strobe !== 1'b1 && cycles - t0 < 60000) @(posedge clock_i);
		t0 = cycles - t0;
		check("duration", 16'h1, 16'(t0 >= per * 400 - 400 && t0 <= per * 400 + 400));
		host_u.sel(1'b1);
		host_u.xfer(8'h00, rx);
		check("result hi", {8'h0, word[15:8]}, {8'h0, rx});
		host_u.xfer(8'h00, rx);
		check("result lo", {8'h0, word[7:0]}, {8'h0, rx});
		host_u.xfer(8'h00, rx);
		check("tail", 16'h0, {8'h0, rx});
		host_u.sel(1'b0);
		$display("conversion test done");
	endtask : t_conv

	initial begin
		repeat (20) @(posedge clock_i);
		rst_i <= 1'b0;
		repeat (8) @(posedge clock_i);
		check("reset mode", 16'h0, {14'h0, power_mode_hi, power_mode_lo});
		check("reset strobe", 16'h1, 16'(conversion_strobe));
		t_modes();
		t_ignore();
		t_conv(8'h87, 8'hA0, 14'h2A5C, 64);
		t_conv(8'h00, 8'hA7, 14'h1234, 125);
		conclude();
	end
endmodule : tb
